// file: verilog/xab_exec.v
// execution datapath for custom call, integerize, long multiply-add,
// field extract, first-bit scan and halt.
// assumes the decoder pulses start with opcode and operands valid that
// cycle, and waits for done before issuing the next one.
`timescale 1ns/10ps
`default_nettype none
`include "xab_map.vh"

// How it works
// - custom call enters loaded microcode, else traps to kernel simulator.
// - byte 54 selects single integerize, byte 74 selects double integerize.
// - 54 and 74 with the FD second byte select g and h formats.
// - extension bits sit below multiplier fraction: 8, 11 or 15 bits.
// - g drops the low 5 extension bits, h drops the low 1.
// - product truncated to 32, 64 or 128 fraction bits before rounding.
// - integer part goes to int result, rounded fraction to fraction result.
// - 7A multiplies signed longwords, adds sign-extended addend, writes quadword.
// - EE writes the located field sign-extended to a longword.
// - EF writes the located field zero-extended to a longword.
// - zero-size extract writes zero and sets Z.
// - EB scans for zero, EA for one, from field bit zero upward.
// - found bit writes its position and clears Z.
// - nothing found writes position one past the field and sets Z.
// - zero-size scan writes start position and sets Z.
// - 00 halts in kernel mode, otherwise raises privileged fault.
module xab_exec (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [7:0] opcode,
    input wire [7:0] opcode2,
    input wire kernel_mode,
    input wire ucode_present,
    input wire [31:0] opnd_a,
    input wire [31:0] opnd_b,
    input wire [31:0] opnd_c,
    input wire [63:0] field_src,
    input wire mulr_sign,
    input wire [63:0] mulr_frac,
    input wire [15:0] mulr_ext,
    input wire muld_sign,
    input wire [63:0] muld_frac,
    output reg done,
    output reg [31:0] res_long,
    output reg [63:0] res_quad,
    output reg [63:0] res_fract,
    output reg res_fract_sign,
    output reg wr_long,
    output reg wr_quad,
    output reg wr_fract,
    output reg cc_n,
    output reg cc_z,
    output reg cc_v,
    output reg cc_c,
    output reg cc_we,
    output reg ucode_enter,
    output reg sim_trap,
    output reg priv_fault,
    output reg halt_req,
    output reg rsvd_fault,
    output reg illegal_op
);
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    // true when the latched opcode is either code of a pair
    function op_pair;
        input [7:0] op;
        input [7:0] code_a;
        input [7:0] code_b;
        begin
            op_pair = (op == code_a) || (op == code_b);
        end
    endfunction

    // negative and zero flags of a longword result
    // shared by both extract forms so they cannot drift apart
    function [1:0] nz_of;
        input [31:0] value;
        begin
            nz_of = {value[31], value == 32'h00000000};
        end
    endfunction

    reg state_reg;
    reg state_next;
    reg [7:0] op_reg;
    reg fd_reg;
    reg kern_reg;
    reg ucode_reg;
    reg [31:0] a_reg;
    reg [31:0] b_reg;
    reg [31:0] c_reg;
    reg [63:0] src_reg;
    reg sgn_reg;
    reg [63:0] mulr_reg;
    reg [15:0] ext_reg;
    reg [63:0] muld_reg;

    // latch the operands so the decoder may move on after start
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg <= 8'h00;
            fd_reg <= 1'b0;
            kern_reg <= 1'b0;
            ucode_reg <= 1'b0;
            a_reg <= 32'h00000000;
            b_reg <= 32'h00000000;
            c_reg <= 32'h00000000;
            src_reg <= 64'h0000000000000000;
            sgn_reg <= 1'b0;
            mulr_reg <= 64'h0000000000000000;
            ext_reg <= 16'h0000;
            muld_reg <= 64'h0000000000000000;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && start) begin
                op_reg <= opcode;
                fd_reg <= (opcode2 == `XAB_OP_PREFIX);
                kern_reg <= kernel_mode;
                ucode_reg <= ucode_present;
                a_reg <= opnd_a;
                b_reg <= opnd_b;
                c_reg <= opnd_c;
                src_reg <= field_src;
                sgn_reg <= mulr_sign ^ muld_sign;
                mulr_reg <= mulr_frac;
                ext_reg <= mulr_ext;
                muld_reg <= muld_frac;
            end
        end
    end

    // two-state sequencer: latch, then compute and answer
    // no back-pressure: a start in the exec cycle is simply ignored
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = start ? ST_EXEC : ST_IDLE;
            ST_EXEC: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // opcode classes of the latched first byte, shared by the result stage
    reg is_ext;
    reg is_scan;
    always @* begin
        is_ext = op_pair(op_reg, `XAB_OP_EXTS, `XAB_OP_EXTZ);
        is_scan = op_pair(op_reg, `XAB_OP_SCAN1, `XAB_OP_SCAN0);
    end

    // integerize format from first and second opcode bytes
    reg is_mod;
    reg [1:0] fmt;
    always @* begin
        is_mod = op_pair(op_reg, `XAB_OP_MODF, `XAB_OP_MODD);
        if (op_reg == `XAB_OP_MODF)
            fmt = fd_reg ? `XAB_FMT_G : `XAB_FMT_F;
        else
            fmt = fd_reg ? `XAB_FMT_H : `XAB_FMT_D;
    end

    // extended multiplier: fraction, then kept extension bits below it
    // unused low positions are zero filled so every format shares one width
    reg [78:0] mulr_x;
    always @* begin
        case (fmt)
            `XAB_FMT_G: mulr_x = {mulr_reg, ext_reg[15:`XAB_DROP_G], 4'h0};
            `XAB_FMT_H: mulr_x = {mulr_reg, ext_reg[15:`XAB_DROP_H]};
            default: mulr_x = {mulr_reg, ext_reg[15:8], 7'h00};
        endcase
    end

    // muld has 32 fraction bits and the extended multiplier 47, so the
    // product's binary point sits at bit 79 with 64 integer bits above it
    wire [142:0] mod_prod;
    xab_mul #(.AW(64), .BW(79)) u_mod_mul (
        .a(muld_reg),
        .b(mulr_x),
        .signed_mode(1'b0),
        .p(mod_prod)
    );

    // keep 128 fraction bits: 79 real, rest zero; cut short formats
    reg [127:0] frac_t;
    reg [31:0] mod_int;
    reg mod_ovf;
    reg [63:0] frac_r;
    always @* begin
        frac_t = {mod_prod[78:0], 49'h0};
        case (fmt)
            `XAB_FMT_F: frac_t = {frac_t[127:96], 96'h0};
            `XAB_FMT_H: frac_t = frac_t;
            default: frac_t = {frac_t[127:64], 64'h0};
        endcase
        // integer bits above the longword are dropped, not flagged
        mod_int = mod_prod[110:79];
        mod_ovf = 1'b0;
        // fraction rounded to the 64-bit result, saturating at the top
        if (frac_t[63] && frac_t[127:64] != 64'hFFFFFFFFFFFFFFFF)
            frac_r = frac_t[127:64] + 64'h0000000000000001;
        else
            frac_r = frac_t[127:64];
    end

    // signed integer part: magnitude negated when the operand signs differ
    reg [31:0] mod_int_s;
    always @* begin
        if (sgn_reg)
            mod_int_s = 32'h00000000 - mod_int;
        else
            mod_int_s = mod_int;
    end

    // signed long multiply plus sign-extended addend
    wire [63:0] lma_prod;
    reg [63:0] lma_sum;
    xab_mul #(.AW(32), .BW(32)) u_lma_mul (
        .a(a_reg),
        .b(b_reg),
        .signed_mode(1'b1),
        .p(lma_prod)
    );
    always @* begin
        lma_sum = lma_prod + {{32{c_reg[31]}}, c_reg};
    end

    // field unit: a=position, b[7:0]=size
    // oversize fields are flagged by the unit; the result stage faults on them
    wire [31:0] fld_s;
    wire [31:0] fld_z;
    wire [31:0] fld_pos;
    wire fld_none;
    wire fld_bad;
    xab_field u_field (
        .src(src_reg),
        .pos(a_reg),
        .size(b_reg[7:0]),
        .want_one(op_reg == `XAB_OP_SCAN1),
        .ext_signed(fld_s),
        .ext_zero(fld_z),
        .find_pos(fld_pos),
        .find_none(fld_none),
        .size_bad(fld_bad)
    );

    // result selection; every output registered, pulses last one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            res_long <= 32'h00000000;
            res_quad <= 64'h0000000000000000;
            res_fract <= 64'h0000000000000000;
            res_fract_sign <= 1'b0;
            wr_long <= 1'b0;
            wr_quad <= 1'b0;
            wr_fract <= 1'b0;
            cc_n <= 1'b0;
            cc_z <= 1'b0;
            cc_v <= 1'b0;
            cc_c <= 1'b0;
            cc_we <= 1'b0;
            ucode_enter <= 1'b0;
            sim_trap <= 1'b0;
            priv_fault <= 1'b0;
            halt_req <= 1'b0;
            rsvd_fault <= 1'b0;
            illegal_op <= 1'b0;
        end else begin
            done <= (state_reg == ST_EXEC);
            wr_long <= 1'b0;
            wr_quad <= 1'b0;
            wr_fract <= 1'b0;
            cc_we <= 1'b0;
            ucode_enter <= 1'b0;
            sim_trap <= 1'b0;
            priv_fault <= 1'b0;
            halt_req <= 1'b0;
            rsvd_fault <= 1'b0;
            illegal_op <= 1'b0;
            if (state_reg == ST_EXEC) begin
                // a trap or fault pulse stands alone, with no result or flag write
                if (op_reg == `XAB_OP_CUSTOM) begin
                    ucode_enter <= ucode_reg;
                    sim_trap <= ~ucode_reg;
                end else if (op_reg == `XAB_OP_HALT) begin
                    halt_req <= kern_reg;
                    priv_fault <= ~kern_reg;
                end else if (is_mod) begin
                    res_long <= mod_int_s;
                    res_fract <= frac_r;
                    res_fract_sign <= sgn_reg & (frac_r != 64'h0);
                    wr_long <= 1'b1;
                    wr_fract <= 1'b1;
                    cc_we <= 1'b1;
                    cc_n <= sgn_reg & ((frac_r != 64'h0) | (mod_int != 32'h0));
                    cc_z <= (frac_r == 64'h0) && (mod_int == 32'h0);
                    cc_v <= mod_ovf;
                    cc_c <= 1'b0;
                end else if (op_reg == `XAB_OP_LMADD) begin
                    res_quad <= lma_sum;
                    wr_quad <= 1'b1;
                    cc_we <= 1'b1;
                    cc_n <= lma_sum[63];
                    cc_z <= (lma_sum == 64'h0);
                    cc_v <= 1'b0;
                    cc_c <= 1'b0;
                end else if (is_ext) begin
                    if (fld_bad) begin
                        rsvd_fault <= 1'b1;
                    end else begin
                        // zero-size field already yields zero from the unit
                        if (op_reg == `XAB_OP_EXTS) begin
                            res_long <= fld_s;
                            {cc_n, cc_z} <= nz_of(fld_s);
                        end else begin
                            res_long <= fld_z;
                            {cc_n, cc_z} <= nz_of(fld_z);
                        end
                        wr_long <= 1'b1;
                        cc_we <= 1'b1;
                        cc_v <= 1'b0;
                        cc_c <= 1'b0;
                    end
                end else if (is_scan) begin
                    if (fld_bad) begin
                        rsvd_fault <= 1'b1;
                    end else begin
                        // zero size: pos plus zero is the start position
                        res_long <= fld_pos;
                        cc_z <= fld_none;
                        cc_n <= 1'b0;
                        cc_v <= 1'b0;
                        cc_c <= 1'b0;
                        wr_long <= 1'b1;
                        cc_we <= 1'b1;
                    end
                end else begin
                    illegal_op <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/xab_map.vh
// opcode, width and format constants for the extended arithmetic and
// bit-field execution datapath; included by xab_exec and xab_field, not by xab_mul.
`ifndef XAB_MAP_VH
`define XAB_MAP_VH

// single-byte opcodes
`define XAB_OP_HALT 8'h00
`define XAB_OP_MODF 8'h54
`define XAB_OP_MODD 8'h74
`define XAB_OP_LMADD 8'h7A
`define XAB_OP_SCAN1 8'hEA
`define XAB_OP_SCAN0 8'hEB
`define XAB_OP_EXTS 8'hEE
`define XAB_OP_EXTZ 8'hEF
`define XAB_OP_CUSTOM 8'hFC
// second byte of the two-byte integerize opcodes
`define XAB_OP_PREFIX 8'hFD

// multiplier extension bits kept per format
`define XAB_EXT_FD 8
`define XAB_EXT_G 11
`define XAB_EXT_H 15
// low bits of the 16-bit extension dropped for g and h
`define XAB_DROP_G 5
`define XAB_DROP_H 1

// fraction length of the truncated product per format
`define XAB_FRAC_F 32
`define XAB_FRAC_DG 64
`define XAB_FRAC_H 128

// format codes
`define XAB_FMT_F 2'h0
`define XAB_FMT_D 2'h1
`define XAB_FMT_G 2'h2
`define XAB_FMT_H 2'h3

// largest legal field size
`define XAB_MAX_SIZE 8'h20

`endif

// file: verilog/xab_field.v
// bit-field extractor and first-bit scanner, purely combinational.
// assumes the operand fetch has placed the field's bytes in src so that
// pos[5:0] is the field's offset inside that 64-bit window.
`timescale 1ns/10ps
`default_nettype none
`include "xab_map.vh"

module xab_field (
    input wire [63:0] src,
    input wire [31:0] pos,
    input wire [7:0] size,
    input wire want_one,
    output reg [31:0] ext_signed,
    output reg [31:0] ext_zero,
    output reg [31:0] find_pos,
    output reg find_none,
    output reg size_bad
);
    reg [63:0] shifted;
    reg [31:0] mask;
    reg [31:0] field;
    integer i;

    // extract, extend and scan from bit zero upward
    always @* begin
        shifted = src >> pos[5:0];
        size_bad = (size > `XAB_MAX_SIZE);
        if (size >= `XAB_MAX_SIZE)
            mask = 32'hFFFFFFFF;
        else
            mask = ~(32'hFFFFFFFF << size[4:0]);
        field = shifted[31:0] & mask;
        ext_zero = field;
        ext_signed = field;
        if (size != 8'h00 && size < `XAB_MAX_SIZE && field[size[4:0] - 5'h01])
            ext_signed = field | ~mask;
        // not found: one past the top of the field, relative to base
        find_pos = pos + {24'h000000, size};
        find_none = 1'b1;
        for (i = 31; i >= 0; i = i - 1) begin
            if (i < size && shifted[i] == want_one) begin
                find_pos = pos + i[31:0];
                find_none = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/xab_mul.v
// two's-complement or unsigned multiplier, combinational.
// assumes the caller registers the product; no pipelining inside.
`timescale 1ns/10ps
`default_nettype none

module xab_mul #(
    parameter AW = 64,
    parameter BW = 79
) (
    input wire [AW-1:0] a,
    input wire [BW-1:0] b,
    input wire signed_mode,
    output reg [AW+BW-1:0] p
);
    reg [AW+BW-1:0] ax;
    reg [AW+BW-1:0] bx;

    // sign or zero extend to full width, then keep the low product bits
    always @* begin
        ax = {{BW{signed_mode & a[AW-1]}}, a};
        bx = {{AW{signed_mode & b[BW-1]}}, b};
        p = ax * bx;
    end
endmodule
`default_nettype wire

// file: bench/xab_chk_checker.sv
// checker for the extended arithmetic and bit-field datapath
// sees only the top ports; bound into every xab_exec instance below
`timescale 1ns/10ps
`default_nettype none
`include "xab_map.vh"
module xab_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic kernel_mode,
    input wire logic ucode_present,
    input wire logic [31:0] opnd_a,
    input wire logic [31:0] opnd_b,
    input wire logic [31:0] opnd_c,
    input wire logic done,
    input wire logic [31:0] res_long,
    input wire logic [63:0] res_quad,
    input wire logic cc_n,
    input wire logic cc_z,
    input wire logic cc_v,
    input wire logic cc_c,
    input wire logic ucode_enter,
    input wire logic sim_trap,
    input wire logic halt_req,
    input wire logic priv_fault
);
    logic signed [63:0] mac;
    // all operands signed so the addend is sign-extended, not zero filled
    assign mac = $signed(opnd_a) * $signed(opnd_b) + $signed(opnd_c);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // one opcode taken, or a field pair with zero or legal nonzero size
    sequence s_op(logic [7:0] op);
        start && opcode == op;
    endsequence
    sequence s_grp(logic [6:0] g, logic z);
        start && opcode[7:1] == g && (opnd_b[7:0] == 8'h00) == z && opnd_b[7:0] <= 8'h20;
    endsequence
    property p_lat;
        $rose(start) |-> ##2 done;
    endproperty
    a_lat: assert property (p_lat) else $error("done not two cycles after start");
    property p_once;
        done |=> !done;
    endproperty
    a_once: assert property (p_once) else $error("done held too long");
    property p_custom;
        s_op(`XAB_OP_CUSTOM) |-> ##2 ucode_enter == $past(ucode_present, 2)
            && sim_trap != $past(ucode_present, 2);
    endproperty
    a_custom: assert property (p_custom) else $error("custom call outcome");
    property p_halt;
        s_op(`XAB_OP_HALT) |-> ##2 halt_req == $past(kernel_mode, 2)
            && priv_fault != $past(kernel_mode, 2);
    endproperty
    a_halt: assert property (p_halt) else $error("halt outcome");
    property p_ext0;
        s_grp(7'h77, 1'b1) |-> ##2 res_long == 32'h0 && cc_z;
    endproperty
    a_ext0: assert property (p_ext0) else $error("empty extract");
    property p_xcc;
        s_grp(7'h77, 1'b0) |-> ##2 !cc_v && !cc_c && cc_n == res_long[31]
            && cc_z == (res_long == 32'h0);
    endproperty
    a_xcc: assert property (p_xcc) else $error("extract flags");
    property p_scan0;
        s_grp(7'h75, 1'b1) |-> ##2 cc_z && res_long == $past(opnd_a, 2);
    endproperty
    a_scan0: assert property (p_scan0) else $error("empty scan");
    property p_mac;
        s_op(`XAB_OP_LMADD) |-> ##2 res_quad == $past(mac, 2) && cc_n == res_quad[63];
    endproperty
    a_mac: assert property (p_mac) else $error("multiply-add sum");
endmodule
bind xab_exec xab_chk i_chk (.*);
`default_nettype wire

// file: bench/xab_dec.sv
// decoder and operand-fetch model, one request at a time
// assumes one done pulse per request; raises hung if it never comes
`timescale 1ns/10ps
`default_nettype none
module xab_fetch (
    input wire logic clk,
    input wire logic done,
    output logic hung,
    output logic start,
    output logic [7:0] opcode,
    output logic [7:0] opcode2,
    output logic kernel_mode,
    output logic ucode_present,
    output logic [31:0] opnd_a,
    output logic [31:0] opnd_b,
    output logic [31:0] opnd_c,
    output logic [63:0] field_src,
    output logic mulr_sign,
    output logic [63:0] mulr_frac,
    output logic [15:0] mulr_ext,
    output logic muld_sign,
    output logic [63:0] muld_frac
);
    // quiet lines until the first request
    initial begin
        {hung, start, opcode, opcode2, kernel_mode, ucode_present} = '0;
        {opnd_a, opnd_b, opnd_c, field_src, mulr_sign, muld_sign} = '0;
        {mulr_frac, mulr_ext, muld_frac} = '0;
    end
    // operand values except the signs stand only in the start cycle, then go inverted so stale use shows
    task automatic issue(input logic [7:0] op, op2, input logic [1:0] fl, sg,
        input logic [31:0] a, b, c, input logic [63:0] src, mf, md, input logic [15:0] me);
        int i;
        @(posedge clk);
        start <= 1'b1;
        {opcode, opcode2, kernel_mode, ucode_present, mulr_sign, muld_sign} <= {op, op2, fl, sg};
        {opnd_a, opnd_b, opnd_c, field_src, mulr_frac, muld_frac, mulr_ext} <= {a, b, c, src, mf, md, me};
        @(posedge clk);
        start <= 1'b0;
        {opnd_a, opnd_b, opnd_c, field_src, mulr_frac, muld_frac, mulr_ext} <= ~{a, b, c, src, mf, md, me};
        for (i = 0; i < 6 && done !== 1'b1; i++) @(negedge clk);
        if (done !== 1'b1) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the extended arithmetic and bit-field datapath
// assumes the decoder model drives every request on a 20 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "xab_map.vh"
module tb_top;
    logic clk, rst_n, start, kernel_mode, ucode_present, mulr_sign, muld_sign, hung, done;
    logic [7:0] opcode, opcode2;
    logic [15:0] mulr_ext;
    logic [31:0] opnd_a, opnd_b, opnd_c, res_long;
    logic [63:0] field_src, mulr_frac, muld_frac, res_quad, res_fract;
    logic res_fract_sign, wr_long, wr_quad, wr_fract, cc_n, cc_z, cc_v, cc_c, cc_we;
    logic ucode_enter, sim_trap, priv_fault, halt_req, rsvd_fault, illegal_op;
    int n_fail = 0;
    int samples_checked = 0;
    xab_exec i_dut (.*);
    xab_fetch i_fetch (.*);
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input logic [63:0] g, e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task op(input logic [7:0] o, input logic [1:0] f, input logic [31:0] a, b,
        input logic [63:0] s);
        i_fetch.issue(o, 8'h00, f, 2'b00, a, b, 32'h0, s, 64'h0, 64'h0, 16'h0);
    endtask
    // every mode pair for the custom call and the halt
    task t_traps;
        int k;
        for (k = 0; k < 4; k++) begin
            op(`XAB_OP_CUSTOM, k[1:0], 32'h0, 32'h0, 64'h0);
            chk({ucode_enter, sim_trap}, {k[0], !k[0]});
            op(`XAB_OP_HALT, k[1:0], 32'h0, 32'h0, 64'h0);
            chk({halt_req, priv_fault}, {k[1], !k[1]});
        end
        op(8'h01, 2'b00, 32'h0, 32'h0, 64'h0);
        chk(illegal_op, 64'h1);
    endtask
    task mi(input logic [7:0] o, input logic g, s, input logic [63:0] mf, md,
        input logic [15:0] me, input logic [63:0] ef, ei);
        i_fetch.issue(o, g ? 8'hFD : 8'h00, 2'b00, {s, 1'b0}, 32'h0, 32'h0, 32'h0, 64'h0,
            mf, md, me);
        chk(res_long, ei);
        chk(res_fract, ef);
        chk({wr_long, wr_fract, cc_we, res_fract_sign}, {3'b111, s && ef != 64'h0});
    endtask
    // low bits decide: truncation length and which extension bits count
    task t_integerize;
        mi(8'h54, 1'b0, 1'b1, 64'h200000000, 64'h180000000, 16'h0, 64'h0, 64'hFFFFFFFD);
        mi(8'h54, 1'b0, 1'b0, 64'h1, 64'h80000000, 16'h0, 64'h0, 64'h0);
        mi(8'h74, 1'b0, 1'b0, 64'h1, 64'h80000000, 16'h0, 64'h80000000, 64'h0);
        mi(8'h74, 1'b0, 1'b0, 64'h0, 64'h100000000, 16'h0100, 64'h1000000, 64'h0);
        mi(8'h54, 1'b1, 1'b0, 64'h100000000, 64'h100000000, 16'h001F, 64'h0, 64'h1);
        mi(8'h54, 1'b1, 1'b0, 64'h0, 64'h100000000, 16'h0020, 64'h200000, 64'h0);
        mi(8'h74, 1'b1, 1'b0, 64'h100000000, 64'h100000000, 16'h0001, 64'h0, 64'h1);
        mi(8'h74, 1'b1, 1'b0, 64'h0, 64'h100000000, 16'h0002, 64'h20000, 64'h0);
        mi(8'h74, 1'b0, 1'b1, 64'h1, 64'h80000000, 16'h0, 64'h80000000, 64'h0);
    endtask
    // negative product with the most negative addend, then the largest positive longword squared
    task t_lmadd;
        i_fetch.issue(`XAB_OP_LMADD, 8'h00, 2'b00, 2'b00, 32'hFFFFFFFE, 32'h3, 32'h80000000,
            64'h0, 64'h0, 64'h0, 16'h0);
        chk({wr_quad, res_quad}, {1'b1, 64'hFFFFFFFF7FFFFFFA});
        i_fetch.issue(`XAB_OP_LMADD, 8'h00, 2'b00, 2'b00, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h1,
            64'h0, 64'h0, 64'h0, 16'h0);
        chk(res_quad, 64'h3FFFFFFF00000002);
    endtask
    // reset in mid-run clears held results; the next request follows at once
    task t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(res_quad, 64'h0);
        chk(res_fract, 64'h0);
        chk({res_fract_sign, cc_n, done}, 64'h0);
        rst_n <= 1'b1;
    endtask
    task fx(input logic [7:0] o, input logic [31:0] a, b, input logic [63:0] s, e);
        op(o, 2'b00, a, b, s);
        chk(res_long, e);
        chk({cc_n, cc_z, cc_v, cc_c}, {e[31], e == 64'h0, 2'b00});
    endtask
    // field edges: top of window, full longword, empty field, oversize
    task t_extract;
        fx(`XAB_OP_EXTS, 32'h4, 32'h4, 64'hA0, 64'hFFFFFFFA);
        fx(`XAB_OP_EXTZ, 32'h4, 32'h4, 64'hA0, 64'hA);
        fx(`XAB_OP_EXTS, 32'h20, 32'h20, 64'h8000000100000000, 64'h80000001);
        fx(`XAB_OP_EXTZ, 32'h3F, 32'h1, 64'h8000000000000000, 64'h1);
        fx(`XAB_OP_EXTS, 32'h4, 32'h0, 64'hFF, 64'h0);
        op(`XAB_OP_EXTZ, 2'b00, 32'h0, 32'h21, 64'h0);
        chk(rsvd_fault, 64'h1);
    endtask
    task sc(input logic [7:0] o, input logic [31:0] a, b, input logic [63:0] s, e,
        input logic z);
        op(o, 2'b00, a, b, s);
        chk({cc_z, res_long}, {z, e[31:0]});
    endtask
    // two target bits in the field: the lower one must win; then no target bit, and an empty field
    task t_scan;
        sc(`XAB_OP_SCAN1, 32'h8, 32'h8, 64'h9000, 64'hC, 1'b0);
        sc(`XAB_OP_SCAN0, 32'h8, 32'h8, 64'h6F00, 64'hC, 1'b0);
        sc(`XAB_OP_SCAN1, 32'h8, 32'h8, 64'h00FF, 64'h10, 1'b1);
        sc(`XAB_OP_SCAN0, 32'h8, 32'h8, 64'hFF00, 64'h10, 1'b1);
        sc(`XAB_OP_SCAN1, 32'h28, 32'h0, 64'hFFFF, 64'h28, 1'b1);
    endtask
    // reset, then each scenario in turn
    initial begin
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        chk({done, res_long, cc_z, halt_req}, 64'h0);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_traps;
        t_integerize;
        t_lmadd;
        t_reset;
        t_extract;
        t_scan;
        end_of_test;
    end
    // a request that never completed ends the run
    always @(posedge hung) begin
        n_fail++;
        end_of_test;
    end
endmodule
`default_nettype wire
